// file: rtl/linefeed_power_alarm.sv
// Power estimation, thermal filter and alarm logic for one linefeed channel
//
// Overview of operation
// (RL1) Discrete: Q1/Q2 power is (|tip| or |ring| + 0.75 V) times own current.
// (RL2) Discrete: Q3-Q6 use battery minus resistor drop (minus ring/tip) times current.
// (RL3) Integrated: six terms, Q3/Q4 battery plus 0.75 V, summed as total power.
// (RL4) Calculation and filter update once per 800 Hz sample period.
// (RL5) Low-pass filter each power value; compare only filtered output to threshold.
// (RL6) Pole is 12-bit plus sign, max 4096, held in bits 15:3.
// (RL7) Software computes pole as 4096/(800*tau)*8, rounded up.
// (RL8) Discrete: three threshold/pole pairs for Q1-2, Q3-4, Q5-6.
// (RL9) Alarm status bit sets on comparator rising edge, stays until cleared.
// (RL10) Six status bits and six enables; cleared enable masks that interrupt.
// (RL11) Integrated: filter total only with pair A pole, compare pair A threshold.
// (RL12) Thermal sense pin selects coarse 1059.6 uW/LSB total scaling.
// (RL13) Integrated: only first status and first enable bit used.
// (RL14) Any alarm forces line OPEN until software changes state, mask ignored.
// (RL15) Total power is 16-bit read value, 0 to 69.44 W.
// (RL16) Pair B threshold is fine scale 31.4 uW/LSB; others 498 uW/LSB.
// (RL17) Software programs thresholds from package, board and airflow.
// (RL18) Filter moves toward sample by pole times 2^-15 each update.
`timescale 1ns/1ps

module linefeed_power_alarm #(
   parameter int SAMPLE_DIV = power_alarm_pkg::SAMPLE_CYCLES
) (
   // Clock and reset
   input  wire logic                                   CLK,
   input  wire logic                                   RST,
   // Register port
   input  wire logic [power_alarm_pkg::ADDR_W-1:0]     ADDR,
   input  wire logic [power_alarm_pkg::DATA_W-1:0]     WDATA,
   input  wire logic                                   WR,
   input  wire logic                                   RD,
   output logic      [power_alarm_pkg::DATA_W-1:0]     RDATA,
   // Sample inputs, magnitudes, same clock domain
   input  wire logic [15:0]                            V_TIP,
   input  wire logic [15:0]                            V_RING,
   input  wire logic [15:0]                            V_BAT,
   input  wire logic [15:0]                            I_Q1,
   input  wire logic [15:0]                            I_Q2,
   input  wire logic [15:0]                            I_Q3,
   input  wire logic [15:0]                            I_Q4,
   input  wire logic [15:0]                            I_Q5,
   input  wire logic [15:0]                            I_Q6,
   input  wire logic [15:0]                            DROP_R6,
   input  wire logic [15:0]                            DROP_R7,
   // Integrated linefeed sense pin
   input  wire logic                                   THERMAL_SENSE_PIN,
   // Linefeed state and interrupt
   output logic      [2:0]                             LINE_STATE,
   output logic                                        FORCE_OPEN,
   output logic                                        IRQ
);
   import power_alarm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [31:0]      div;
      logic [2:0]       sync;
      logic             integ;
      logic [15:0]      total;
      logic [2:0][15:0] thr;
      logic [2:0][15:0] pole;
      logic [5:0][15:0] filt;
      logic [5:0]       cmp;
      logic [5:0]       status;
      logic [5:0]       enable;
      logic [2:0]       line;
      logic             forced;
      logic [15:0]      rdata;
      logic             irq;
   } state_t;

   state_t s_q, s_d;

   function automatic logic [15:0] sat16(input logic [39:0] v);
      sat16 = (v[39:16] != 24'h0) ? 16'hffff : v[15:0];
   endfunction

   function automatic logic [15:0] sub0(input logic [15:0] a, input logic [15:0] b);
      sub0 = (a > b) ? 16'(a - b) : 16'h0000;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic [15:0]        cur      [6];
   logic [15:0]        vce      [6];
   logic [15:0]        pwr      [6];
   logic [39:0]        term     [6];
   logic [15:0]        lim      [6];
   logic [15:0]        pole_of  [6];
   logic [15:0]        filt_in  [6];
   logic [15:0]        filt_nxt [6];
   logic [39:0]        tot;
   logic [15:0]        total_now;
   logic [15:0]        tip_up;
   logic [15:0]        ring_up;
   logic [15:0]        bat_up;
   logic [15:0]        bat_ring;
   logic [15:0]        bat_tip;
   logic               tick;
   logic [5:0]         cmp_now;
   logic [5:0]         rise;

   // Transistor currents in index order
   assign cur[0] = I_Q1;
   assign cur[1] = I_Q2;
   assign cur[2] = I_Q3;
   assign cur[3] = I_Q4;
   assign cur[4] = I_Q5;
   assign cur[5] = I_Q6;

   // Offset sums, and headroom terms floored at zero
   assign tip_up   = 16'(V_TIP + VCE_OFFSET);
   assign ring_up  = 16'(V_RING + VCE_OFFSET);
   assign bat_up   = 16'(V_BAT + VCE_OFFSET);
   assign bat_ring = sub0(V_BAT, V_RING);
   assign bat_tip  = sub0(V_BAT, V_TIP);

   ////////////////////////////////////////////////////////////////////////////
   // Collector-emitter voltage per transistor
   always_comb begin
      // (RL1) Tip and ring plus fixed offset
      vce[0] = tip_up;
      vce[1] = ring_up;
      if (s_q.integ) begin
         // (RL3) Battery plus offset, then headroom
         vce[2] = bat_up;
         vce[3] = bat_up;
         vce[4] = bat_ring;
         vce[5] = bat_tip;
      end else begin
         // (RL2) Discrete terms less resistor drop
         vce[2] = sub0(V_BAT, DROP_R7);
         vce[3] = sub0(V_BAT, DROP_R6);
         vce[4] = sub0(bat_ring, DROP_R7);
         vce[5] = sub0(bat_tip, DROP_R6);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power, pair selection and thermal filter step per transistor
   for (genvar g = 0; g < 6; g++) begin : g_xtor
      // Pair B sits on the fine threshold scale
      localparam int SHIFT = (g == 2 || g == 3) ? SHIFT_FINE : SHIFT_COARSE;
      logic        [31:0] prod;
      logic signed [17:0] diff;
      logic signed [31:0] step;
      logic signed [31:0] nxt;

      // (RL16) Volt times amp, pair scale
      assign prod   = 32'(vce[g]) * 32'(cur[g]);
      assign pwr[g] = sat16(40'(prod >> SHIFT));
      // (RL12) Coarse scale for the total
      assign term[g] = 40'(prod >> SHIFT_TOTAL);
      // (RL8) Threshold and pole of own pair
      assign lim[g]     = s_q.thr[g / 2];
      assign pole_of[g] = s_q.pole[g / 2];
      // (RL11) First filter takes the total when integrated
      assign filt_in[g] = (g == 0 && s_q.integ) ? total_now : pwr[g];
      // (RL18) Step toward sample, pole word times 2^-15
      assign diff = $signed({2'b00, filt_in[g]}) - $signed({2'b00, s_q.filt[g]});
      assign step = (32'(diff) * $signed({19'h0, pole_of[g][POLE_MSB:POLE_LSB]})) >>> 12;
      // Wide sum: a pole above 4096 may overshoot past 17 bits
      assign nxt  = 32'($signed({2'b00, s_q.filt[g]})) + step;
      assign filt_nxt[g] = (nxt < 0) ? 16'h0000 : (nxt > 32'sh0000ffff) ? 16'hffff : nxt[15:0];
   end

   // (RL3) Sum of the six terms, (RL15) saturated to 16 bits
   assign tot       = term[0] + term[1] + term[2] + term[3] + term[4] + term[5];
   assign total_now = sat16(tot);

   always_comb begin
      s_d = s_q;
      // Integrated mode pin, three stages, change when last two agree
      s_d.sync = {s_q.sync[1:0], THERMAL_SENSE_PIN};
      if (s_q.sync[2] == s_q.sync[1]) begin
         s_d.integ = s_q.sync[2];
      end
      // (RL4) Sample rate enable
      tick = (s_q.div == 32'(SAMPLE_DIV - 1));
      s_d.div = tick ? 32'h0 : s_q.div + 32'h1;
      // Filter update and threshold compare on the sample tick
      s_d.total = s_q.total;
      cmp_now = s_q.cmp;
      if (tick) begin
         if (s_q.integ) begin
            // (RL12) Coarse total, (RL15) 16-bit monitor
            s_d.total = total_now;
            // (RL11) Only the total filtered and compared
            s_d.filt[0] = filt_nxt[0];
            cmp_now = {5'h00, filt_nxt[0] > lim[0]};
         end else begin
            for (int i = 0; i < 6; i++) begin
               // (RL5) Compare filtered output only
               s_d.filt[i] = filt_nxt[i];
               cmp_now[i] = filt_nxt[i] > lim[i];
            end
         end
      end
      s_d.cmp = cmp_now;
      // (RL9) Rising edge of comparator output
      rise = cmp_now & ~s_q.cmp;
      // (RL13) Integrated mode uses first bit only
      if (s_q.integ) begin
         rise = rise & 6'h01;
      end
      s_d.rdata = 16'h0000;
      // Register writes
      if (WR) begin
         if (ADDR == REG_PAIR_A_THRESH) begin
            s_d.thr[0] = WDATA;
         end else if (ADDR == REG_PAIR_B_THRESH) begin
            s_d.thr[1] = WDATA;
         end else if (ADDR == REG_PAIR_C_THRESH) begin
            s_d.thr[2] = WDATA;
         end else if (ADDR == REG_PAIR_A_POLE) begin
            // (RL6) Pole kept in bits 15:3
            s_d.pole[0] = {WDATA[POLE_MSB:POLE_LSB], 3'h0};
         end else if (ADDR == REG_PAIR_B_POLE) begin
            s_d.pole[1] = {WDATA[POLE_MSB:POLE_LSB], 3'h0};
         end else if (ADDR == REG_PAIR_C_POLE) begin
            s_d.pole[2] = {WDATA[POLE_MSB:POLE_LSB], 3'h0};
         end else if (ADDR == REG_ALARM_STATUS) begin
            s_d.status = s_q.status & ~WDATA[5:0];
         end else if (ADDR == REG_ALARM_ENABLE) begin
            s_d.enable = WDATA[5:0];
         end else if (ADDR == REG_LINE_CONTROL) begin
            s_d.line = WDATA[2:0];
            s_d.forced = 1'b0;
         end
      end
      // (RL9) Set wins over clear
      s_d.status = s_d.status | rise;
      // (RL14) Force OPEN regardless of mask
      if (rise != 6'h00) begin
         s_d.line = LINE_OPEN;
         s_d.forced = 1'b1;
      end
      // (RL10) Masked interrupt
      s_d.irq = (s_d.status & s_d.enable) != 6'h00;
      // Register reads, data stands one cycle
      if (RD) begin
         if (ADDR == REG_TOTAL_POWER) begin
            s_d.rdata = s_q.total;
         end else if (ADDR == REG_PAIR_A_THRESH) begin
            s_d.rdata = s_q.thr[0];
         end else if (ADDR == REG_PAIR_B_THRESH) begin
            s_d.rdata = s_q.thr[1];
         end else if (ADDR == REG_PAIR_C_THRESH) begin
            s_d.rdata = s_q.thr[2];
         end else if (ADDR == REG_PAIR_A_POLE) begin
            s_d.rdata = s_q.pole[0];
         end else if (ADDR == REG_PAIR_B_POLE) begin
            s_d.rdata = s_q.pole[1];
         end else if (ADDR == REG_PAIR_C_POLE) begin
            s_d.rdata = s_q.pole[2];
         end else if (ADDR == REG_ALARM_STATUS) begin
            s_d.rdata = {10'h000, s_q.status};
         end else if (ADDR == REG_ALARM_ENABLE) begin
            s_d.rdata = {10'h000, s_q.enable};
         end else if (ADDR == REG_LINE_CONTROL) begin
            s_d.rdata = {11'h000, s_q.integ, s_q.forced, s_q.line};
         end else if (ADDR >= REG_FILTERED_BASE) begin
            // Filtered values of transistors 1..6 (index 0..5)
            s_d.rdata = (4'(ADDR - REG_FILTERED_BASE) < 4'h6) ?
                        s_q.filt[3'(ADDR - REG_FILTERED_BASE)] : 16'h0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s_q <= '0;
         s_q.thr <= {THRESH_RESET, THRESH_RESET, THRESH_RESET};
         s_q.pole <= {POLE_RESET, POLE_RESET, POLE_RESET};
         s_q.enable <= ENABLE_RESET;
         s_q.line <= LINE_OPEN;
      end else begin
         s_q <= s_d;
      end
   end

   assign RDATA = s_q.rdata;
   assign LINE_STATE = s_q.line;
   assign FORCE_OPEN = s_q.forced;
   assign IRQ = s_q.irq;
endmodule // linefeed_power_alarm

// file: include/power_alarm_pkg.sv
// Constants and register map for the linefeed power alarm block
package power_alarm_pkg;
   // Register bus
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam logic [3:0] REG_TOTAL_POWER     = 4'h0;
   localparam logic [3:0] REG_PAIR_A_THRESH   = 4'h1;
   localparam logic [3:0] REG_PAIR_B_THRESH   = 4'h2;
   localparam logic [3:0] REG_PAIR_C_THRESH   = 4'h3;
   localparam logic [3:0] REG_PAIR_A_POLE     = 4'h4;
   localparam logic [3:0] REG_PAIR_B_POLE     = 4'h5;
   localparam logic [3:0] REG_PAIR_C_POLE     = 4'h6;
   localparam logic [3:0] REG_ALARM_STATUS    = 4'h7;
   localparam logic [3:0] REG_ALARM_ENABLE    = 4'h8;
   localparam logic [3:0] REG_LINE_CONTROL    = 4'h9;
   localparam logic [3:0] REG_FILTERED_BASE   = 4'ha;
   // Reset values
   localparam logic [15:0] THRESH_RESET       = 16'hffff;
   localparam logic [15:0] POLE_RESET         = 16'h0000;
   localparam logic [5:0]  ENABLE_RESET       = 6'h00;
   // Pole field position within its word
   localparam int POLE_LSB = 3;
   localparam int POLE_MSB = 15;
   // Fixed collector-emitter offset, 0.75 V in sample units
   localparam int VOLT_LSB_UV = 4907;
   localparam int VCE_OFFSET_UV = 750000;
   localparam logic [15:0] VCE_OFFSET = 16'((VCE_OFFSET_UV + VOLT_LSB_UV / 2) / VOLT_LSB_UV);
   // Update rate
   localparam int CLK_HZ = 125000000;
   localparam int SAMPLE_HZ = 800;
   localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
   // Power scaling: shifts from volt*amp product down to threshold units
   localparam int SHIFT_FINE = 12;
   localparam int SHIFT_COARSE = 16;
   localparam int SHIFT_TOTAL = 17;
   // Linefeed states
   localparam logic [2:0] LINE_OPEN = 3'h0;
endpackage

// file: test/alarm_checker_assertions.sv
// Port-level assertions for the linefeed power alarm
`timescale 1ns/1ps
module alarm_checker (
   // Clock, reset and register port
   input wire logic                                CLK,
   input wire logic                                RST,
   input wire logic [power_alarm_pkg::ADDR_W-1:0]  ADDR,
   input wire logic [power_alarm_pkg::DATA_W-1:0]  WDATA,
   input wire logic                                WR,
   input wire logic                                RD,
   input wire logic [power_alarm_pkg::DATA_W-1:0]  RDATA,
   // Line and interrupt
   input wire logic [2:0]                          LINE_STATE,
   input wire logic                                FORCE_OPEN,
   input wire logic                                IRQ
);
   import power_alarm_pkg::*;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   rdata_idle_zero_a: assert property (!$past(RD) |-> RDATA == 16'h0000)
      else $error("read data not zero outside read");
   thresh_readback_a: assert property ((WR && ADDR inside {[REG_PAIR_A_THRESH:REG_PAIR_C_THRESH]}) ##1
      (RD && ADDR == $past(ADDR)) |=> RDATA == $past(WDATA, 2)) else $error("threshold readback wrong");
   pole_low_bits_a: assert property ($past(RD) && $past(ADDR) inside {[REG_PAIR_A_POLE:REG_PAIR_C_POLE]}
      |-> RDATA[2:0] == 3'h0) else $error("pole low bits not zero");
   status_width_a: assert property ($past(RD) && $past(ADDR) == REG_ALARM_STATUS
      |-> RDATA[15:6] == 10'h000) else $error("status upper bits set");
   irq_mask_a: assert property (WR && ADDR == REG_ALARM_ENABLE && WDATA[5:0] == 6'h00
      |-> ##[1:2] !IRQ) else $error("interrupt not masked");
   force_state_a: assert property ($rose(FORCE_OPEN) |-> LINE_STATE == LINE_OPEN)
      else $error("forced without open state");
   forced_hold_a: assert property (FORCE_OPEN && !(WR && ADDR == REG_LINE_CONTROL)
      |=> FORCE_OPEN && LINE_STATE == LINE_OPEN) else $error("forced open state not held");
   line_write_a: assert property (WR && ADDR == REG_LINE_CONTROL
      |=> LINE_STATE == 3'($past(WDATA)) && !FORCE_OPEN) else $error("line write not applied");
endmodule // alarm_checker

bind linefeed_power_alarm alarm_checker u_alarm_checker (.CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA,
   .LINE_STATE, .FORCE_OPEN, .IRQ);

// file: test/linefeed_analog_model.sv
// Behavioural analog front end: sample magnitudes of one linefeed channel
`timescale 1ns/1ps
module linefeed_analog_model (
   // Clock and sample step
   input  wire logic        CLK,
   input  wire logic        STEP,
   // Raw draw in, plausible magnitudes out
   input  wire logic [15:0] RAW [11],
   output logic      [15:0] VAL [11]
);
   // Battery above tip, ring and drop from the first step on; all zero before it
   initial foreach (VAL[k]) VAL[k] = 16'h0000;
   always @(posedge CLK) begin
      if (STEP) begin
         foreach (VAL[k]) VAL[k] <= 16'(k < 2 ? 1000 + RAW[k] % 1000 : k == 2 ? 9000 + RAW[k] % 1000 :
            k < 9 ? 100 + RAW[k] % 900 : RAW[k] % 256);
      end
   end
endmodule // linefeed_analog_model

// file: test/linefeed_power_alarm_tb.sv
// Self-checking bench for the linefeed power alarm
`timescale 1ns/1ps
module linefeed_power_alarm_tb;
   import power_alarm_pkg::*;
   logic        clk, rst, wr, rd, step, sense, fo, irq;
   logic [3:0]  addr;
   logic [15:0] wdata, rdata, q;
   logic [2:0]  ls;
   logic [15:0] raw [11];
   logic [15:0] val [11];
   logic [5:0]  st;
   int          n_errors, checked, cyc, thr [3];
   linefeed_analog_model FE (.CLK(clk), .STEP(step), .RAW(raw), .VAL(val));
   linefeed_power_alarm #(.SAMPLE_DIV(8)) DUT (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .V_TIP(val[0]), .V_RING(val[1]), .V_BAT(val[2]), .I_Q1(val[3]), .I_Q2(val[4]),
      .I_Q3(val[5]), .I_Q4(val[6]), .I_Q5(val[7]), .I_Q6(val[8]), .DROP_R6(val[9]), .DROP_R7(val[10]),
      .THERMAL_SENSE_PIN(sense), .LINE_STATE(ls), .FORCE_OPEN(fo), .IRQ(irq));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_errors++;
         complete_run();
      end
   end
   ////////////////////////////////////////
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      checked++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask
   task automatic wr_reg(logic [3:0] a, logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(logic [3:0] a);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 q = rdata;
   endtask
   task automatic new_sample();
      foreach (raw[k]) raw[k] <= 16'($urandom);
      step <= 1'b1;
      @(posedge clk);
      step <= 1'b0;
      #1;
   endtask
   task automatic complete_run();
      if (n_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Reference power per transistor, or the total when ig is set
   function automatic int pw(int k, bit ig);
      int off = int'(VCE_OFFSET);
      int d6 = ig ? -off : int'(val[9]);
      int d7 = ig ? -off : int'(val[10]);
      int p [6];
      p[0] = (val[0] + off) * val[3];
      p[1] = (val[1] + off) * val[4];
      p[2] = (val[2] - d7) * val[5];
      p[3] = (val[2] - d6) * val[6];
      p[4] = (val[2] - val[1] - (ig ? 0 : d7)) * val[7];
      p[5] = (val[2] - val[0] - (ig ? 0 : d6)) * val[8];
      // Total: each term scaled on its own, then summed
      if (ig) begin
         foreach (p[j]) p[j] = p[j] >>> SHIFT_TOTAL;
         return p.sum();
      end
      return (k == 2 || k == 3) ? p[k] >>> SHIFT_FINE : p[k] >>> SHIFT_COARSE;
   endfunction
   ////////////////////////////////////////
   initial begin
      {rst, wr, rd, step, sense, addr, wdata} = {1'b1, 24'h0};
      foreach (raw[k]) raw[k] = 16'h0000;
      void'($urandom(3727));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      wr_reg(REG_TOTAL_POWER, 16'h1234);
      for (int a = 0; a < 16; a++) begin
         rd_reg(4'(a));
         chk("reset value", (a > 0 && a < 4) ? 16'hffff : 16'h0000, q);
      end
      wr_reg(REG_PAIR_B_THRESH, 16'h1b5e);
      rd_reg(REG_PAIR_B_THRESH);
      chk("threshold", 16'h1b5e, q);
      // Pole for 1.25 ms time constant
      for (int a = 4; a < 7; a++) wr_reg(4'(a), 16'h8007);
      rd_reg(REG_PAIR_C_POLE);
      chk("pole", 16'h8000, q);
      wr_reg(REG_LINE_CONTROL, 16'h0001);
      new_sample();
      repeat (40) @(posedge clk);
      for (int k = 0; k < 6; k++) begin
         rd_reg(REG_FILTERED_BASE + 4'(k));
         chk("filtered", 16'(pw(k, 1'b0)), q);
      end
      thr = '{pw(0, 1'b0), pw(3, 1'b0) - 1, pw(5, 1'b0)};
      for (int j = 0; j < 3; j++) wr_reg(REG_PAIR_A_THRESH + 4'(j), 16'(thr[j]));
      repeat (40) @(posedge clk);
      for (int k = 0; k < 6; k++) st[k] = pw(k, 1'b0) > thr[k / 2];
      rd_reg(REG_ALARM_STATUS);
      chk("status", {10'h0, st}, q);
      chk("irq masked", 16'h0000, {15'h0, irq});
      chk("forced", 16'h0008, {12'h0, fo, ls});
      wr_reg(REG_ALARM_ENABLE, 16'h003f);
      repeat (2) @(posedge clk);
      #1 chk("irq", 16'h0001, {15'h0, irq});
      wr_reg(REG_ALARM_ENABLE, 16'h0000);
      wr_reg(REG_ALARM_STATUS, 16'h003f);
      rd_reg(REG_ALARM_STATUS);
      chk("cleared", 16'h0000, q);
      wr_reg(REG_LINE_CONTROL, 16'h0001);
      repeat (40) @(posedge clk);
      #1 chk("line", 16'h0001, {12'h0, fo, ls});
      wr_reg(REG_PAIR_A_THRESH, 16'hffff);
      sense <= 1'b1;
      repeat (8) @(posedge clk);
      new_sample();
      repeat (40) @(posedge clk);
      rd_reg(REG_TOTAL_POWER);
      chk("total", 16'(pw(0, 1'b1)), q);
      rd_reg(REG_FILTERED_BASE);
      chk("filtered total", 16'(pw(0, 1'b1)), q);
      wr_reg(REG_ALARM_ENABLE, 16'h003f);
      wr_reg(REG_PAIR_A_THRESH, 16'h0000);
      repeat (40) @(posedge clk);
      rd_reg(REG_ALARM_STATUS);
      chk("total alarm", 16'h0001, q);
      chk("total irq", 16'h0001, {15'h0, irq});
      complete_run();
   end
endmodule // linefeed_power_alarm_tb
